// >>> hw/fsy_pkg.sv
// Purpose: Shared constants for the frame-sync block
// Assumes: pclk at 40 MHz
// Notes: Frame periods are pclk cycle counts
package fsy_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 40000000; // Core clock rate
   localparam int unsigned PULSE_MIN_NS = 1000; // Master pulse least width
   localparam int unsigned PULSE_CYC = (PULSE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned PER_NTSC60 = 667334; // 59.94 Hz frame
   localparam int unsigned PER_PAL50 = 800000; // 50 Hz frame
   localparam int unsigned PER_NTSC30 = 1334668; // 29.97 Hz frame
   localparam int unsigned PER_PAL25 = 1600000; // 25 Hz frame
   localparam int unsigned PER_30HZ = 1333333; // 30 Hz guard, rounded down
   localparam int unsigned SLOW_DIV = 4; // Slow-config pulses per frame
   localparam int unsigned MARK_DLY = 64; // Pulse to video-marker delay
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] OFF_CTRL = 12'h000; // Role and video setup
   localparam logic [11:0] OFF_STAT = 12'h004; // Active role and state
   localparam logic [11:0] OFF_CNT = 12'h008; // Accepted and dropped pulses
   localparam int unsigned CTRL_ROLE_LSB = 0; // 2-bit role
   localparam int unsigned CTRL_PAL_BIT = 2; // 1 = PAL
   localparam int unsigned CTRL_AVG_BIT = 3; // 1 = averager on
   localparam int unsigned CTRL_CFG_LSB = 4; // 2-bit sensor configuration
   localparam logic [31:0] CTRL_RST = 32'h0000_0000; // Reset value
   typedef enum logic [1:0] {FSY_OFF = 2'b00, FSY_MASTER = 2'b01, FSY_SLAVE = 2'b10} fsy_role_t;
   typedef enum logic [1:0] {FSY_C60 = 2'b00, FSY_C30 = 2'b01, FSY_SLOW = 2'b10} fsy_cfg_t;
endpackage

// >>> hw/fsy_frame_sync.sv
// Purpose: Frame-sync master/slave logic with APB registers
// Assumes: Restart pulse marks a core restart; pin is asynchronous
// Notes: Settings are stored in CTRL but used only after restart
// Operation
// - Role latched from stored setup at restart
// - Master emits one pulse per frame
// - Master period follows standard and averager
// - Master pulse held at least 1 us
// - 640/30 config uses only 30/25 Hz
// - Slave frame starts on accepted rising edge
// - Drop pulses faster than 30 Hz in NTSC with averager or 640/30 config
// - Slave video held until valid pulse
// - Video marker follows pulse after delay
// - Slow config frames every Nth pulse
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
module fsy_frame_sync
   import fsy_pkg::*;
#(
   parameter int unsigned MAX_PER = PER_PAL25 // Frame counter range
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic restart, // Core restart pulse
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_sync_pin_i, // Pin level
   output logic frame_sync_pin_o, // Pin drive value
   output logic frame_sync_pin_oe_n, // Low while driving
   output logic sensor_array_start, // Sensor frame start pulse
   output logic video_frame_mark, // Digital video marker pulse
   output logic video_enable // Video output allowed
);
   localparam int CW = $clog2(MAX_PER + 1);
   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [31:0] ctrl_q, ctrl_d; // Stored power-on setup
   fsy_role_t role_q, role_d; // Active role
   logic pal_q, pal_d, avg_q, avg_d; // Active video setup
   fsy_cfg_t cfg_q, cfg_d; // Active sensor configuration
   logic [15:0] acc_q, acc_d, drop_q, drop_d; // Pulse counters
   logic [2:0] sync_q, sync_d; // Pin synchroniser chain
   logic pin_q, pin_d; // Filtered pin level
   logic [CW-1:0] frm_q, frm_d; // Frame or guard counter
   logic [CW-1:0] per_w; // Active frame period
   logic [7:0] pw_q, pw_d; // Master pulse width counter
   logic [7:0] md_q, md_d; // Marker delay counter
   logic [1:0] div_q, div_d; // Slow pulse divider
   logic armed_q, armed_d; // Slave has a valid pulse
   logic start_q, start_d, mark_q, mark_d, drv_q, drv_d;
   logic wr_en, rise, guard;

   // Period lookup from active setup
   function automatic logic [CW-1:0] fsy_period(input logic pal, input logic avg, input fsy_cfg_t cfg);
      if (cfg != FSY_C60 || avg)
         fsy_period = pal ? CW'(PER_PAL25) : CW'(PER_NTSC30);
      else
         fsy_period = pal ? CW'(PER_PAL50) : CW'(PER_NTSC60);
   endfunction

   assign per_w = fsy_period(pal_q, avg_q, cfg_q);
   assign wr_en = psel && penable && pwrite;
   assign rise = pin_d && !pin_q;
   assign guard = !pal_q && (avg_q || cfg_q == FSY_C30);
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      ctrl_d = ctrl_q;
      role_d = role_q;
      pal_d = pal_q;
      avg_d = avg_q;
      cfg_d = cfg_q;
      acc_d = acc_q;
      drop_d = drop_q;
      sync_d = {sync_q[1:0], frame_sync_pin_i};
      pin_d = pin_q;
      frm_d = frm_q;
      pw_d = pw_q;
      md_d = md_q;
      div_d = div_q;
      armed_d = armed_q;
      start_d = 1'b0;
      mark_d = 1'b0;
      drv_d = drv_q;
      prdata = 32'h0000_0000;
      // Change counts once stages two and three agree
      if (sync_q[2] == sync_q[1])
         pin_d = sync_q[2];
      // Register write; no effect until restart
      if (wr_en && paddr == OFF_CTRL)
         ctrl_d = {26'h000_0000, pwdata[5:0]};
      // Register read mux
      if (psel && !pwrite)
      begin
         unique case (paddr)
            OFF_CTRL: prdata = ctrl_q;
            OFF_STAT: prdata = {25'h000_0000, armed_q, cfg_q, avg_q, pal_q, role_q};
            OFF_CNT: prdata = {drop_q, acc_q};
            default: prdata = 32'h0000_0000;
         endcase
      end
      // Latch stored setup on restart
      if (restart)
      begin
         role_d = fsy_role_t'(ctrl_q[CTRL_ROLE_LSB +: 2]);
         if (role_d == 2'b11)
            role_d = FSY_OFF;
         pal_d = ctrl_q[CTRL_PAL_BIT];
         avg_d = ctrl_q[CTRL_AVG_BIT];
         cfg_d = fsy_cfg_t'(ctrl_q[CTRL_CFG_LSB +: 2]);
         if (cfg_d == 2'b11)
            cfg_d = FSY_C60;
         frm_d = '0;
         armed_d = 1'b0;
         drv_d = 1'b0;
         div_d = '0;
      end
      else
      begin
         if (frm_q != '1)
            frm_d = frm_q + 1'b1;
         unique case (role_q)
            FSY_SLAVE:
            begin
               // Accept edge unless inside the 30 Hz guard
               if (rise)
               begin
                  if (guard && armed_q && frm_q < CW'(PER_30HZ))
                     drop_d = drop_q + 1'b1;
                  else
                  begin
                     acc_d = acc_q + 1'b1;
                     frm_d = '0;
                     armed_d = 1'b1;
                     div_d = div_q + 1'b1;
                     if (cfg_q != FSY_SLOW || div_q == 2'(SLOW_DIV - 1))
                     begin
                        start_d = 1'b1;
                        div_d = '0;
                     end
                  end
               end
            end
            default:
            begin
               // Master and disabled run own timing; pin ignored
               if (frm_q >= per_w - 1'b1)
               begin
                  frm_d = '0;
                  start_d = 1'b1;
                  if (role_q == FSY_MASTER)
                  begin
                     drv_d = 1'b1;
                     pw_d = 8'(PULSE_CYC);
                  end
               end
               else if (pw_q != 8'h00)
                  pw_d = pw_q - 1'b1;
               else
                  drv_d = 1'b0;
            end
         endcase
      end
      // Marker some time after frame start
      // Restart drops a pending marker so a fresh slave role stays quiet
      if (restart)
         md_d = 8'h00;
      else if (start_q)
         md_d = 8'(MARK_DLY);
      else if (md_q != 8'h00)
      begin
         md_d = md_q - 1'b1;
         mark_d = (md_q == 8'h01);
      end
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= CTRL_RST;
         role_q <= FSY_OFF;
         pal_q <= 1'b0;
         avg_q <= 1'b0;
         cfg_q <= FSY_C60;
         acc_q <= 16'h0000;
         drop_q <= 16'h0000;
         sync_q <= 3'h0;
         pin_q <= 1'b0;
         frm_q <= '0;
         pw_q <= 8'h00;
         md_q <= 8'h00;
         div_q <= 2'h0;
         armed_q <= 1'b0;
         start_q <= 1'b0;
         mark_q <= 1'b0;
         drv_q <= 1'b0;
      end
      else if (clk_en)
      begin
         ctrl_q <= ctrl_d;
         role_q <= role_d;
         pal_q <= pal_d;
         avg_q <= avg_d;
         cfg_q <= cfg_d;
         acc_q <= acc_d;
         drop_q <= drop_d;
         sync_q <= sync_d;
         pin_q <= pin_d;
         frm_q <= frm_d;
         pw_q <= pw_d;
         md_q <= md_d;
         div_q <= div_d;
         armed_q <= armed_d;
         start_q <= start_d;
         mark_q <= mark_d;
         drv_q <= drv_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign frame_sync_pin_o = drv_q;
   assign frame_sync_pin_oe_n = (role_q != FSY_MASTER);
   assign sensor_array_start = start_q;
   assign video_frame_mark = mark_q;
   assign video_enable = (role_q != FSY_SLAVE) || armed_q;
endmodule

// >>> verification/fsy_far_end.sv
// Purpose: Far-end camera that drives the sync pin
// Assumes: Pin idles low between pulses
// Notes: Width counted in pclk cycles
`timescale 1ns/10ps
module fsy_far_end(
   input wire logic pclk,
   input wire logic go, // Start one pulse
   input wire logic [7:0] width, // High time in cycles
   output logic pin
);
   logic [7:0] cnt_q = 8'h00; // Cycles left high
   // Floor of 4 cycles keeps every pulse at least 100 ns
   always @(posedge pclk)
   begin
      if (go) cnt_q <= (width < 8'h04) ? 8'h04 : width;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
   end
   assign pin = (cnt_q != 8'h00);
endmodule

// >>> verification/fsy_frame_sync_monitor.sv
// Purpose: Port checks for the frame-sync block
// Assumes: clk_en held high
// Notes: Bound at the foot of this file
`timescale 1ns/10ps
module fsy_frame_sync_monitor(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   input wire logic psel,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_sync_pin_o,
   input wire logic frame_sync_pin_oe_n,
   input wire logic sensor_array_start,
   input wire logic video_frame_mark,
   input wire logic video_enable
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] hi_q; // Pin high run length
   logic [7:0] hi_d;
   // Saturates so a stuck pin cannot wrap to a short count
   always_comb hi_d = frame_sync_pin_o ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) hi_q <= 8'h00;
      else hi_q <= hi_d;
   end
   AST_APB_OK: assert property (psel |-> pready && !pslverr) else $error("bad apb answer");
   AST_UNMAPPED: assert property (psel && !pwrite && paddr == 12'h00C |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_ROLE_PIN:
      assert property ($changed(frame_sync_pin_oe_n) |-> $past(restart) || $past(restart, 2)) else $error("pin drive moved");
   AST_ROLE_VIDEO:
      assert property ($fell(video_enable) |-> $past(restart) || $past(restart, 2)) else $error("video dropped");
   AST_START_ONE: assert property (sensor_array_start |=> !sensor_array_start) else $error("long start");
   AST_MARK_DELAY:
      assert property (video_frame_mark |-> $past(sensor_array_start, 65)) else $error("marker delay wrong");
   AST_VIDEO_HOLD: assert property (!video_enable |-> !video_frame_mark) else $error("marker while held");
   AST_PULSE_WIDTH: assert property ($fell(frame_sync_pin_o) |-> hi_q >= 8'h28) else $error("short pulse");
endmodule
bind fsy_frame_sync fsy_frame_sync_monitor i_mon(.pclk, .presetn, .restart, .psel, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .frame_sync_pin_o, .frame_sync_pin_oe_n, .sensor_array_start, .video_frame_mark, .video_enable);

// >>> verification/frame_sync_master_slave_tb_top.sv
// Purpose: Self-checking bench for the frame-sync block
// Assumes: Frame periods far longer than the run
// Notes: Reads are checked by a watcher from a queue
`timescale 1ns/10ps
module frame_sync_master_slave_tb_top
   import fsy_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic restart = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic go = 1'b0; // Far end trigger
   logic [7:0] width = 8'h05;
   logic [31:0] prdata;
   logic pready, pslverr, pin, pin_o, oe_n, start, mark, ven;
   int failures = 0;
   int checks = 0;
   int starts = 0; // Frame starts seen
   int cyc = 0; // Clock edges seen by the watcher
   int t_start = 0; // Edge of the latest frame start
   int marks = 0; // Video markers seen
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   always #12.5 pclk = ~pclk;
   fsy_frame_sync i_fsy_frame_sync(.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .restart(restart), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_sync_pin_i(pin), .frame_sync_pin_o(pin_o), .frame_sync_pin_oe_n(oe_n),
      .sensor_array_start(start), .video_frame_mark(mark), .video_enable(ven));
   fsy_far_end i_fsy_far_end(.pclk(pclk), .go(go), .width(width), .pin(pin));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task check(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Reads note the expected value; the watcher compares it
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
      begin
         exp_q.push_back(d);
         msk_q.push_back(m);
      end
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task restart_core();
      @(posedge pclk);
      restart <= 1'b1;
      @(posedge pclk);
      restart <= 1'b0;
      repeat (4) @(posedge pclk);
      #1;
   endtask
   task fire(input logic [7:0] w);
      @(posedge pclk);
      width <= w;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (40) @(posedge pclk);
      #1;
   endtask
   task final_report();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Watcher and sequence
   // ----------------------------------------
   always @(posedge pclk)
   begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      begin
         check(prdata & msk_q[0], exp_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      cyc++;
      if (start === 1'b1) starts++;
      if (start === 1'b1) t_start = cyc;
      // Marker must trail its frame start by the fixed delay
      if (mark === 1'b1)
      begin
         marks++;
         check(32'(cyc - t_start), 32'(MARK_DLY + 1));
      end
   end
   initial
   begin
      void'($urandom(92));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFF_CTRL, CTRL_RST, 32'hFFFF_FFFF);
      apb(1'b1, 12'h00C, $urandom, 32'h0000_0000);
      apb(1'b0, 12'h00C, 32'h0000_0000, 32'hFFFF_FFFF);
      apb(1'b1, OFF_CTRL, 32'h0000_000A, 32'h0000_0000);
      apb(1'b0, OFF_STAT, 32'h0000_0000, 32'h0000_003F);
      restart_core();
      apb(1'b0, OFF_STAT, 32'h0000_000A, 32'h0000_003F);
      check({30'h0, ven, oe_n}, 32'h0000_0001);
      fire(8'h05 + 8'($urandom % 16));
      check(32'(starts), 32'h0000_0001);
      check({31'h0, ven}, 32'h0000_0001);
      fire(8'h05 + 8'($urandom % 16));
      check(32'(starts), 32'h0000_0001);
      apb(1'b0, OFF_CNT, 32'h0001_0001, 32'hFFFF_FFFF);
      // Disabled role: pin pulses must change nothing
      apb(1'b1, OFF_CTRL, 32'h0000_0000, 32'h0000_0000);
      restart_core();
      // One pulse only; video enable, pin drive and start count are checked
      fire(8'h05 + 8'($urandom % 16));
      check({30'h0, ven, oe_n}, 32'h0000_0003);
      check(32'(starts), 32'h0000_0001);
      // PAL slow slave: no guard, one frame per SLOW_DIV accepted pulses
      apb(1'b1, OFF_CTRL, 32'h0000_0026, 32'h0000_0000);
      restart_core();
      repeat (SLOW_DIV - 1) fire(8'h05 + 8'($urandom % 16));
      check(32'(starts), 32'h0000_0001);
      fire(8'h05 + 8'($urandom % 16));
      check(32'(starts), 32'h0000_0002);
      apb(1'b0, OFF_CNT, 32'h0001_0005, 32'hFFFF_FFFF);
      // Let the last marker come out
      repeat (30) @(posedge pclk);
      #1;
      check(32'(marks), 32'h0000_0002);
      apb(1'b1, OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
      restart_core();
      check({31'h0, oe_n}, 32'h0000_0000);
      check({31'h0, pin_o}, 32'h0000_0000);
      final_report();
   end
   initial
   begin
      #(25 * 20000);
      failures++;
      final_report();
   end
endmodule
